/* File: include/udcrc_cfg.svh */
// Constants shared by the receive-path CRC handling block and its host end.
`ifndef UDCRC_CFG_SVH
`define UDCRC_CFG_SVH
`define UDCRC_CLK_NS 4
`define UDCRC_TO_NS 64
`define UDCRC_TO_CYC (((`UDCRC_TO_NS) + (`UDCRC_CLK_NS) - 1) / (`UDCRC_CLK_NS))
`define UDCRC_CRC_INIT 16'hFFFF
`define UDCRC_CRC_POLY 16'hA001
`define UDCRC_CRC_RESID 16'hB001
`define UDCRC_CRC_RACE 16'h7FF2
`define UDCRC_MAX_PKT 4'h8
`define UDCRC_CRC_BYTES 4'h2
`define UDCRC_FIFO_DEPTH 16
`define UDCRC_FIFO_FREE_MAX 5'h10
`define UDCRC_PKT_ROOM 5'h0A
`define UDCRC_HS_FAILS 3'h3
`define UDCRC_FS_RETRIES 3'h4
`endif

/* File: include/udcrc_pkg.sv */
// Types and the CRC step shared by both ends of the link.
`include "udcrc_cfg.svh"
package udcrc_pkg;
  typedef enum logic [1:0] {UDCRC_TOK_OUT, UDCRC_TOK_PING} udcrc_tok_e;
  typedef enum logic [1:0] {UDCRC_HS_ACK, UDCRC_HS_NAK} udcrc_hs_e;

  // Reflected CRC16 over one byte, least significant bit first.
  function automatic logic [15:0] udcrc_crc8(input logic [15:0] c,
                                             input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ `UDCRC_CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction
endpackage

/* File: include/udcrc_link_if.sv */
// Packet-level link between the host end and the device end.
`timescale 1ns/1ps
interface udcrc_link_if (
  input wire logic clk_sys
);
  import udcrc_pkg::*;
  logic tok_vld;
  udcrc_tok_e tok_pid;
  logic dat_vld;
  logic [7:0] dat;
  logic dat_last;
  logic hs_vld;
  udcrc_hs_e hs_pid;
  modport host (output tok_vld, tok_pid, dat_vld, dat, dat_last,
                input hs_vld, hs_pid);
  modport dev (input tok_vld, tok_pid, dat_vld, dat, dat_last,
               output hs_vld, hs_pid);
endinterface

/* File: src/udcrc_dev.sv */
// Device end: receive path with CRC check, flush, handshake and FIFO.
`timescale 1ns/1ps
`include "udcrc_cfg.svh"
module udcrc_dev (
  input wire logic clk_sys,
  input wire logic rst_n,
  udcrc_link_if.dev lnk,
  input wire logic ep_iso,
  input wire logic race_emul,
  input wire logic rd_req,
  output logic [7:0] rd_dat,
  output logic rd_vld,
  output logic rx_evt,
  output logic [3:0] rx_len,
  output logic rx_crc_err
);
  import udcrc_pkg::*;

  typedef enum logic [1:0] {DS_IDLE, DS_DATA, DS_END} udcrc_dst_e;

  // Advances a wrapping FIFO pointer by a byte count.
  function automatic logic [4:0] ptr_add(input logic [4:0] p,
                                         input logic [3:0] n);
    ptr_add = p + {1'b0, n};
  endfunction

  udcrc_dst_e st_r;
  logic [7:0] mem_r [`UDCRC_FIFO_DEPTH];
  logic [4:0] wr_ptr_r;
  logic [4:0] tmp_ptr_r;
  logic [4:0] rd_ptr_r;
  logic [15:0] crc_r;
  logic [15:0] crc_nxt;
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  logic [7:0] prev_r;
  logic nak_r;
  logic crc_ok_r;
  logic [15:0] field_r;
  logic [3:0] len_r;
  logic [4:0] free;
  logic room;
  logic take;
  logic race;
  logic bad;
  logic hs_vld_r;
  udcrc_hs_e hs_pid_r;
  logic [7:0] rd_dat_r;
  logic rd_vld_r;
  logic rx_evt_r;
  logic [3:0] rx_len_r;
  logic rx_crc_err_r;

  assign free = `UDCRC_FIFO_FREE_MAX - (wr_ptr_r - rd_ptr_r);
  assign room = (free >= `UDCRC_PKT_ROOM);
  assign take = (st_r == DS_DATA) && lnk.dat_vld && !nak_r &&
                (cnt_r < (`UDCRC_MAX_PKT + `UDCRC_CRC_BYTES));
  assign crc_nxt = udcrc_crc8(crc_r, lnk.dat);
  assign cnt_nxt = take ? cnt_r + 4'h1 : cnt_r;
  // The race needs a good CRC of the fixed value on a receive; it is
  // only ever produced on request, since the crossing here is coherent.
  assign race = race_emul && ep_iso && crc_ok_r &&
                (field_r == `UDCRC_CRC_RACE);
  assign bad = !crc_ok_r || race;

  // Control, bulk, interrupt and isochronous all walk this same machine.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st_r <= DS_IDLE;
    end else begin
      unique case (st_r)
        DS_IDLE: begin
          if (lnk.tok_vld && lnk.tok_pid == UDCRC_TOK_OUT) begin
            st_r <= DS_DATA;
          end
        end
        DS_DATA: begin
          if (lnk.dat_vld && lnk.dat_last) begin
            st_r <= DS_END;
          end
        end
        DS_END: begin
          st_r <= DS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      crc_r <= `UDCRC_CRC_INIT;
      cnt_r <= 4'h0;
      prev_r <= 8'h00;
      nak_r <= 1'b0;
    end else if (st_r == DS_IDLE && lnk.tok_vld &&
                 lnk.tok_pid == UDCRC_TOK_OUT) begin
      crc_r <= `UDCRC_CRC_INIT;
      cnt_r <= 4'h0;
      nak_r <= !room;
    end else if (take) begin
      crc_r <= crc_nxt;
      cnt_r <= cnt_nxt;
      prev_r <= lnk.dat;
    end
  end

  // End of packet and the CRC verdict land in one register stage, so
  // no consumer can ever see one without the other.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      crc_ok_r <= 1'b0;
      field_r <= 16'h0000;
      len_r <= 4'h0;
    end else if (st_r == DS_DATA && lnk.dat_vld && lnk.dat_last) begin
      crc_ok_r <= (crc_nxt == `UDCRC_CRC_RESID) &&
                  (cnt_nxt >= `UDCRC_CRC_BYTES);
      field_r <= {lnk.dat, prev_r};
      len_r <= (cnt_nxt >= `UDCRC_CRC_BYTES) ?
               cnt_nxt - `UDCRC_CRC_BYTES : 4'h0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (take) begin
      mem_r[tmp_ptr_r[3:0]] <= lnk.dat;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      wr_ptr_r <= 5'h00;
      tmp_ptr_r <= 5'h00;
    end else if (st_r == DS_END) begin
      if (!nak_r && (ep_iso || !bad)) begin
        wr_ptr_r <= ptr_add(wr_ptr_r, len_r);
        tmp_ptr_r <= ptr_add(wr_ptr_r, len_r);
      end else begin
        tmp_ptr_r <= wr_ptr_r;
      end
    end else if (take) begin
      tmp_ptr_r <= ptr_add(tmp_ptr_r, 4'h1);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      hs_vld_r <= 1'b0;
      hs_pid_r <= UDCRC_HS_NAK;
    end else begin
      hs_vld_r <= 1'b0;
      if (st_r == DS_IDLE && lnk.tok_vld &&
          lnk.tok_pid == UDCRC_TOK_PING) begin
        hs_vld_r <= 1'b1;
        hs_pid_r <= room ? UDCRC_HS_ACK : UDCRC_HS_NAK;
      end else if (st_r == DS_END && !ep_iso) begin
        if (nak_r) begin
          hs_vld_r <= 1'b1;
          hs_pid_r <= UDCRC_HS_NAK;
        end else if (!bad) begin
          hs_vld_r <= 1'b1;
          hs_pid_r <= UDCRC_HS_ACK;
        end
        // A bad packet stays silent so the host times out and resends.
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rx_evt_r <= 1'b0;
      rx_len_r <= 4'h0;
      rx_crc_err_r <= 1'b0;
    end else begin
      rx_evt_r <= 1'b0;
      if (st_r == DS_END && !nak_r) begin
        if (ep_iso) begin
          rx_evt_r <= 1'b1;
          rx_crc_err_r <= bad;
          rx_len_r <= race ? len_r - 4'h1 : len_r;
        end else if (!bad) begin
          rx_evt_r <= 1'b1;
          rx_crc_err_r <= 1'b0;
          rx_len_r <= len_r;
        end
      end
    end
  end

  // Software may read past the reported count, which is how the byte
  // hidden by a short count is recovered.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rd_ptr_r <= 5'h00;
      rd_dat_r <= 8'h00;
      rd_vld_r <= 1'b0;
    end else begin
      rd_vld_r <= 1'b0;
      if (rd_req && rd_ptr_r != wr_ptr_r) begin
        rd_dat_r <= mem_r[rd_ptr_r[3:0]];
        rd_vld_r <= 1'b1;
        rd_ptr_r <= ptr_add(rd_ptr_r, 4'h1);
      end
    end
  end

  assign lnk.hs_vld = hs_vld_r;
  assign lnk.hs_pid = hs_pid_r;
  assign rd_dat = rd_dat_r;
  assign rd_vld = rd_vld_r;
  assign rx_evt = rx_evt_r;
  assign rx_len = rx_len_r;
  assign rx_crc_err = rx_crc_err_r;

endmodule // udcrc_dev

/* File: src/udcrc_host.sv */
// Host end: sends packets, times out, retries, pings and resets.
`timescale 1ns/1ps
`include "udcrc_cfg.svh"
module udcrc_host (
  input wire logic clk_sys,
  input wire logic rst_n,
  udcrc_link_if.host lnk,
  input wire logic usr_go,
  input wire logic [3:0] usr_len,
  input wire logic [7:0] usr_seed,
  input wire logic usr_iso,
  input wire logic usr_hs,
  input wire logic [1:0] usr_bad,
  output logic usr_busy,
  output logic usr_done,
  output logic usr_dev_reset
);
  import udcrc_pkg::*;

  typedef enum logic [2:0] {
    HS_IDLE, HS_TOK, HS_DATA, HS_WAIT, HS_PING, HS_PWAIT
  } udcrc_hst_e;

  udcrc_hst_e st_r;
  logic [3:0] len_r;
  logic [7:0] seed_r;
  logic iso_r;
  logic hs_r;
  logic [1:0] bad_r;
  logic [3:0] idx_r;
  logic [15:0] crc_r;
  logic [15:0] crc_tx;
  logic [2:0] fails_r;
  logic [7:0] tmr_r;
  logic tmo;
  logic [7:0] byte_nxt;
  logic tok_vld_r;
  udcrc_tok_e tok_pid_r;
  logic dat_vld_r;
  logic [7:0] dat_r;
  logic dat_last_r;
  logic busy_r;
  logic done_r;
  logic reset_r;

  // A corrupted attempt flips one CRC bit so the device sees a bad packet.
  assign crc_tx = ~crc_r ^ {15'h0000, (bad_r != 2'h0)};
  assign byte_nxt = (idx_r < len_r) ? seed_r + {4'h0, idx_r} :
                    (idx_r == len_r) ? crc_tx[7:0] : crc_tx[15:8];
  assign tmo = (tmr_r == 8'(`UDCRC_TO_CYC));

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st_r <= HS_IDLE;
      len_r <= 4'h0;
      seed_r <= 8'h00;
      iso_r <= 1'b0;
      hs_r <= 1'b0;
      bad_r <= 2'h0;
      idx_r <= 4'h0;
      crc_r <= `UDCRC_CRC_INIT;
      fails_r <= 3'h0;
      tmr_r <= 8'h00;
      tok_vld_r <= 1'b0;
      tok_pid_r <= UDCRC_TOK_OUT;
      dat_vld_r <= 1'b0;
      dat_r <= 8'h00;
      dat_last_r <= 1'b0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
      reset_r <= 1'b0;
    end else begin
      tok_vld_r <= 1'b0;
      dat_vld_r <= 1'b0;
      dat_last_r <= 1'b0;
      done_r <= 1'b0;
      reset_r <= 1'b0;
      tmr_r <= tmr_r + 8'h01;
      unique case (st_r)
        HS_IDLE: begin
          if (usr_go) begin
            len_r <= (usr_len > `UDCRC_MAX_PKT) ? `UDCRC_MAX_PKT : usr_len;
            seed_r <= usr_seed;
            iso_r <= usr_iso;
            hs_r <= usr_hs;
            bad_r <= usr_bad;
            fails_r <= 3'h0;
            busy_r <= 1'b1;
            st_r <= HS_TOK;
          end
        end
        HS_TOK: begin
          tok_vld_r <= 1'b1;
          tok_pid_r <= UDCRC_TOK_OUT;
          idx_r <= 4'h0;
          crc_r <= `UDCRC_CRC_INIT;
          st_r <= HS_DATA;
        end
        HS_DATA: begin
          dat_vld_r <= 1'b1;
          dat_r <= byte_nxt;
          idx_r <= idx_r + 4'h1;
          if (idx_r < len_r) begin
            crc_r <= udcrc_crc8(crc_r, byte_nxt);
          end
          if (idx_r == len_r + 4'h1) begin
            dat_last_r <= 1'b1;
            tmr_r <= 8'h00;
            if (bad_r != 2'h0) begin
              bad_r <= bad_r - 2'h1;
            end
            st_r <= iso_r ? HS_IDLE : HS_WAIT;
            done_r <= iso_r;
            busy_r <= !iso_r;
          end
        end
        HS_WAIT: begin
          if (lnk.hs_vld && lnk.hs_pid == UDCRC_HS_ACK) begin
            done_r <= 1'b1;
            busy_r <= 1'b0;
            st_r <= HS_IDLE;
          end else if (lnk.hs_vld) begin
            st_r <= HS_TOK;
          end else if (tmo) begin
            if (hs_r && fails_r + 3'h1 == `UDCRC_HS_FAILS) begin
              fails_r <= 3'h0;
              st_r <= HS_PING;
            end else if (!hs_r &&
                         fails_r + 3'h1 == `UDCRC_FS_RETRIES) begin
              fails_r <= 3'h0;
              reset_r <= 1'b1;
              st_r <= HS_TOK;
            end else begin
              fails_r <= fails_r + 3'h1;
              st_r <= HS_TOK;
            end
          end
        end
        HS_PING: begin
          tok_vld_r <= 1'b1;
          tok_pid_r <= UDCRC_TOK_PING;
          tmr_r <= 8'h00;
          st_r <= HS_PWAIT;
        end
        HS_PWAIT: begin
          if (lnk.hs_vld && lnk.hs_pid == UDCRC_HS_ACK) begin
            st_r <= HS_TOK;
          end else if (lnk.hs_vld || tmo) begin
            st_r <= HS_PING;
          end
        end
        default: begin
          st_r <= HS_IDLE;
        end
      endcase
    end
  end

  assign lnk.tok_vld = tok_vld_r;
  assign lnk.tok_pid = tok_pid_r;
  assign lnk.dat_vld = dat_vld_r;
  assign lnk.dat = dat_r;
  assign lnk.dat_last = dat_last_r;
  assign usr_busy = busy_r;
  assign usr_done = done_r;
  assign usr_dev_reset = reset_r;

endmodule // udcrc_host

/* File: bench/udcrc_assertions.sv */
// Checker for the packet link between the host end and the device end.
`timescale 1ns/1ps
module udcrc_assertions (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic tok_vld,
  input udcrc_pkg::udcrc_tok_e tok_pid,
  input wire logic dat_vld,
  input wire logic [7:0] dat,
  input wire logic dat_last,
  input wire logic hs_vld,
  input udcrc_pkg::udcrc_hs_e hs_pid
);
  import udcrc_pkg::*;
  logic ping_r;
  logic [1:0] outs_r;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  always_ff @(posedge clk_sys) begin
    ping_r <= rst_n && tok_vld && tok_pid == UDCRC_TOK_PING;
  end
  // Tokens since the last packet ACK, saturating: counting tokens rather
  // than failures only loosens the check, it never makes it fire falsely.
  always_ff @(posedge clk_sys) begin
    if (!rst_n || (hs_vld && hs_pid == UDCRC_HS_ACK && !ping_r)) begin
      outs_r <= 2'h0;
    end else if (tok_vld && tok_pid == UDCRC_TOK_OUT && outs_r != 2'h3) begin
      outs_r <= outs_r + 2'h1;
    end
  end
  sequence s_ping;
    tok_vld && tok_pid == UDCRC_TOK_PING;
  endsequence
  sequence s_end;
    dat_vld && dat_last;
  endsequence
  a_ping_answer: assert property (s_ping |=> hs_vld)
    else $error("ping left unanswered");
  a_ping_after_three: assert property (s_ping |-> outs_r == 2'h3)
    else $error("ping sent before three failed tries");
  a_ack_timing: assert property (hs_vld && hs_pid == UDCRC_HS_ACK
    |-> $past(dat_last, 2) || ping_r)
    else $error("ack without a packet end or ping");
  a_hs_pulse: assert property (hs_vld |=> !hs_vld)
    else $error("handshake longer than one cycle");
  a_tok_pulse: assert property (tok_vld |=> !tok_vld)
    else $error("token longer than one cycle");
  a_bytes_run: assert property (dat_vld && !dat_last |=> dat_vld)
    else $error("gap inside a packet");
  a_end_idle: assert property (s_end |=> !tok_vld && !dat_vld && !hs_vld)
    else $error("no idle cycle after packet end");
  a_last_byte: assert property (dat_last |-> dat_vld)
    else $error("packet end without a byte");
  a_out_data: assert property (tok_vld && tok_pid == UDCRC_TOK_OUT
    |=> dat_vld && !dat_last)
    else $error("out token not followed by data");
  a_hs_quiet: assert property (hs_vld |-> !dat_vld && !tok_vld)
    else $error("handshake overlaps host traffic");
endmodule // udcrc_assertions

/* File: bench/testbench.sv */
// Self-checking bench for the two link ends joined back to back.
`timescale 1ns/1ps
module testbench;
  import udcrc_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic dev_on = 1'b1;
  logic ep_iso = 1'b0;
  logic race_emul = 1'b0;
  logic rd_req = 1'b0;
  logic usr_go = 1'b0;
  logic [3:0] usr_len = 4'h0;
  logic [7:0] usr_seed = 8'h00;
  logic usr_iso = 1'b0;
  logic usr_hs = 1'b0;
  logic [1:0] usr_bad = 2'h0;
  logic [7:0] rd_dat;
  logic rd_vld, rx_evt, rx_crc_err, usr_busy, usr_done, usr_dev_reset;
  logic [3:0] rx_len;
  int bad_count = 0;
  int n_checks = 0;
  int evts = 0, ev0 = 0, hss = 0, h0 = 0, naks = 0, pings = 0, resets = 0;
  always #2 clk_sys = ~clk_sys;
  udcrc_link_if lnk (.clk_sys(clk_sys));
  // Once dev_on is cleared, the device stays held until the host's reset pulse has been counted.
  udcrc_dev u_udcrc_dev (.clk_sys(clk_sys),
    .rst_n(rst_n && (dev_on || resets != 0)),
    .lnk(lnk.dev), .ep_iso(ep_iso), .race_emul(race_emul),
    .rd_req(rd_req), .rd_dat(rd_dat), .rd_vld(rd_vld), .rx_evt(rx_evt),
    .rx_len(rx_len), .rx_crc_err(rx_crc_err));
  udcrc_host u_udcrc_host (.clk_sys(clk_sys), .rst_n(rst_n),
    .lnk(lnk.host), .usr_go(usr_go), .usr_len(usr_len),
    .usr_seed(usr_seed), .usr_iso(usr_iso), .usr_hs(usr_hs),
    .usr_bad(usr_bad), .usr_busy(usr_busy), .usr_done(usr_done),
    .usr_dev_reset(usr_dev_reset));
  udcrc_assertions u_udcrc_assertions (.clk_sys(clk_sys), .rst_n(rst_n),
    .tok_vld(lnk.tok_vld), .tok_pid(lnk.tok_pid), .dat_vld(lnk.dat_vld),
    .dat(lnk.dat), .dat_last(lnk.dat_last), .hs_vld(lnk.hs_vld),
    .hs_pid(lnk.hs_pid));
  // Strobes last a full cycle, so the falling edge sees each one once.
  always @(negedge clk_sys) begin
    if (rx_evt === 1'b1) evts++;
    if (lnk.hs_vld === 1'b1) hss++;
    if (lnk.hs_vld === 1'b1 && lnk.hs_pid === UDCRC_HS_NAK) naks++;
    if (lnk.tok_vld === 1'b1 && lnk.tok_pid === UDCRC_TOK_PING) pings++;
    if (usr_dev_reset === 1'b1) resets++;
  end
  task automatic chk(input string nm, input logic [31:0] got,
                     input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %0h, seen %0h", nm, exp, got);
    end
  endtask
  task automatic go(input logic [3:0] l, input logic [7:0] s,
                    input logic iso, input logic hs, input logic [1:0] b);
    ev0 = evts;
    h0 = hss;
    usr_len = l;
    usr_seed = s;
    usr_iso = iso;
    usr_hs = hs;
    usr_bad = b;
    ep_iso = iso;
    usr_go = 1'b1;
    @(negedge clk_sys);
    usr_go = 1'b0;
  endtask
  task automatic fin(input logic [3:0] l, input logic err);
    for (int i = 0; i < 900 && usr_done !== 1'b1; i++) @(negedge clk_sys);
    chk("usr_done", usr_done, 1'b1);
    repeat (4) @(negedge clk_sys);
    chk("rx_evt count", evts, ev0 + 1);
    chk("rx_len", rx_len, l);
    chk("rx_crc_err", rx_crc_err, err);
  endtask
  task automatic rd(input int n, input logic [7:0] s, input logic ck,
                    input logic em);
    rd_req = 1'b1;
    for (int i = 0; i < n; i++) begin
      @(negedge clk_sys);
      chk("rd_vld", rd_vld, 1'b1);
      if (ck) chk("rd_dat", rd_dat, s + i[7:0]);
    end
    rd_req = em;
    @(negedge clk_sys);
    if (em) chk("fifo empty", rd_vld, 1'b0);
    rd_req = 1'b0;
  endtask
  task automatic stop_test;
    $display("checks %0d, mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // All scenarios need a few hundred cycles; allow ample margin.
  initial begin
    #60000;
    bad_count++;
    stop_test;
  end
  initial begin
    repeat (2) @(negedge clk_sys);
    rst_n = 1'b1;
    go(4'h8, 8'h10, 1'b0, 1'b1, 2'h0);
    fin(4'h8, 1'b0);
    chk("handshakes", hss - h0, 1);
    go(4'h3, 8'h40, 1'b0, 1'b1, 2'h0);
    repeat (60) @(negedge clk_sys);
    chk("usr_busy", usr_busy, 1'b1);
    chk("nak seen", naks != 0, 1);
    chk("early delivery", evts, ev0);
    rd(8, 8'h10, 1'b1, 1'b0);
    fin(4'h3, 1'b0);
    rd(3, 8'h40, 1'b1, 1'b1);
    go(4'h5, 8'h20, 1'b0, 1'b1, 2'h1);
    fin(4'h5, 1'b0);
    chk("handshakes", hss - h0, 1);
    chk("pings", pings, 0);
    rd(5, 8'h20, 1'b1, 1'b1);
    go(4'h2, 8'h30, 1'b0, 1'b1, 2'h3);
    fin(4'h2, 1'b0);
    chk("pings", pings, 1);
    rd(2, 8'h30, 1'b1, 1'b1);
    dev_on = 1'b0;
    go(4'h4, 8'h50, 1'b0, 1'b0, 2'h0);
    fin(4'h4, 1'b0);
    chk("device resets", resets, 1);
    rd(4, 8'h50, 1'b1, 1'b1);
    go(4'h6, 8'h60, 1'b1, 1'b1, 2'h1);
    fin(4'h6, 1'b1);
    chk("iso handshakes", hss - h0, 0);
    rd(6, 8'h60, 1'b1, 1'b1);
    race_emul = 1'b1;
    go(4'h7, 8'h70, 1'b1, 1'b0, 2'h0);
    fin(4'h7, 1'b0);
    rd(rx_len + rx_crc_err, 8'h70, 1'b1, 1'b1);
    go(4'h2, 8'hA0, 1'b0, 1'b1, 2'h0);
    fin(4'h2, 1'b0);
    chk("handshakes", hss - h0, 1);
    rd(2, 8'hA0, 1'b1, 1'b1);
    race_emul = 1'b0;
    stop_test;
  end
endmodule // testbench
